// [src/serial_format_pkg.sv]
package serial_format_pkg;
  // Register word indices; the byte address is four times the index
  localparam logic [3:0] IDX_FORMAT = 4'h4;
  localparam logic [3:0] IDX_MODEM = 4'h5;
  localparam logic [3:0] IDX_DATA = 4'h6;
  localparam logic [3:0] IDX_AUX = 4'h7;
  localparam logic [3:0] IDX_IMASK = 4'h8;
  localparam logic [3:0] IDX_IMASK_WR = 4'h9;
  localparam logic [3:0] IDX_LSTAT = 4'ha;
  // Field positions
  localparam int FMT_STOP = 2;
  localparam int FMT_PEN = 3;
  localparam int FMT_PS_LO = 4;
  localparam int FMT_FLOW_LO = 6;
  localparam int MC_DTR = 0;
  localparam int MC_RTS = 1;
  localparam int MC_DRS = 2;
  localparam int AUX_DRV_A = 3;
  localparam int AUX_DRV_B = 2;
  localparam int AUX_RCV_A = 1;
  localparam int AUX_RCV_B = 0;
  // Reset values
  localparam logic [7:0] FORMAT_RESET = 8'h03;
  localparam logic [7:0] MODEM_RESET = 8'h00;
  localparam logic [7:0] IMASK_RESET = 8'h00;
  localparam logic [1:0] FLOW_NOOP = 2'h0;
  localparam logic [1:0] FLOW_XON = 2'h1;
  localparam logic [1:0] FLOW_OFF = 2'h3;
  // Timing: 25 MHz clock, bit rate as a parameter of its own
  localparam int CLK_HZ = 25000000;
  localparam int BAUD = 9600;
  localparam logic [11:0] BIT_CYCLES = 12'(CLK_HZ / BAUD);
  localparam logic [11:0] HALF_BIT_CYCLES = 12'(CLK_HZ / BAUD / 2);
  localparam logic [7:0] XON_CHAR = 8'h11;
  localparam logic [7:0] XOFF_CHAR = 8'h13;
endpackage

// [src/serial_format_modem_ctrl.sv]
module serial_format_modem_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic avs_response_err,
  // Serial line
  output logic txd,
  input wire logic rxd,
  // Modem lines
  output logic rts,
  output logic dtr,
  output logic rate_select,
  // Optional circuits
  output logic aux_driver_a,
  output logic aux_driver_b,
  input wire logic aux_receiver_a,
  input wire logic aux_receiver_b,
  // Alternative layout select, strap from same clock domain
  input wire logic alt_layout
);
  localparam int MC_DTR = serial_format_pkg::MC_DTR;
  localparam int MC_RTS = serial_format_pkg::MC_RTS;
  localparam int MC_DRS = serial_format_pkg::MC_DRS;
  localparam int FMT_PEN = serial_format_pkg::FMT_PEN;
  localparam int FMT_STOP = serial_format_pkg::FMT_STOP;
  localparam int FMT_PS_LO = serial_format_pkg::FMT_PS_LO;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic [7:0] format;
    logic [7:0] modem;
    logic [7:0] imask;
    logic [1:0] aux_drv;
    logic xon_enable;
    logic tx_paused;
    logic [7:0] tx_hold;
    logic tx_hold_full;
    tx_state_t tx_state;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [11:0] tx_count;
    logic [1:0] tx_half_left;
    logic txd;
    rx_state_t rx_state;
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic [11:0] rx_count;
    logic [7:0] rx_buf;
    logic rx_full;
    logic [2:0] rxd_sync;
    logic [3:0] aux_sync;
    logic [31:0] rdata;
    logic ack;
    logic err;
    logic rts;
    logic dtr;
    logic rate_sel;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [3:0] data_len;
  logic par_bit;
  logic [3:0] frame_bits;
  logic bus_req;
  logic [3:0] idx;
  logic [7:0] modem_live;
  logic [7:0] tx_data;
  logic data_wr;

  always_comb begin
    data_len = 4'd5 + {2'b00, state_reg.format[1:0]};
    // Parity must not see holding bits above the character length
    tx_data = state_reg.tx_hold & ~(8'hff << data_len);
    // odd, even, always one, always zero
    case (state_reg.format[FMT_PS_LO +: 2])
      2'b00: par_bit = ~^tx_data;
      2'b01: par_bit = ^tx_data;
      2'b10: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
    frame_bits = data_len + {3'b000, state_reg.format[FMT_PEN]};
    bus_req = (avs_read | avs_write) & ~state_reg.ack;
    idx = avs_address[5:2];
    data_wr = bus_req & avs_write & avs_byteenable[0] & (idx == serial_format_pkg::IDX_DATA);
    // live line states in write positions
    modem_live = {5'h00, rate_select, rts, dtr};
  end

  always_comb begin
    state_next = state_reg;
    state_next.ack = 1'b0;
    state_next.err = 1'b0;
    state_next.rxd_sync = {state_reg.rxd_sync[1:0], rxd};
    state_next.aux_sync = {state_reg.aux_sync[1:0], aux_receiver_a, aux_receiver_b};
    if (bus_req) begin
      state_next.ack = 1'b1;
      state_next.rdata = 32'h0;
      if (avs_write && avs_byteenable[0]) begin
        // only the low byte is kept, upper lanes discarded
        case (idx)
          serial_format_pkg::IDX_FORMAT: begin
            // stored bits act as switch settings
            state_next.format[5:0] = avs_writedata[5:0];
            if (!alt_layout) begin
              // 00 leaves the handshake setting as it was
              if (avs_writedata[7:6] != serial_format_pkg::FLOW_NOOP) begin
                state_next.format[7:6] = avs_writedata[7:6];
              end
              if (avs_writedata[7:6] == serial_format_pkg::FLOW_XON) begin
                state_next.xon_enable = 1'b1;
              end else if (avs_writedata[7:6] == serial_format_pkg::FLOW_OFF) begin
                state_next.xon_enable = 1'b0;
                state_next.tx_paused = 1'b0;
              end
            end
          end
          serial_format_pkg::IDX_MODEM: state_next.modem = {5'h00, avs_writedata[2:0]};
          serial_format_pkg::IDX_DATA: begin
            state_next.tx_hold = avs_writedata[7:0];
            state_next.tx_hold_full = 1'b1;
          end
          // drivers from bits 3 and 2
          serial_format_pkg::IDX_AUX: state_next.aux_drv =
            avs_writedata[serial_format_pkg::AUX_DRV_B +: 2];
          serial_format_pkg::IDX_IMASK_WR: state_next.imask = {4'h0, avs_writedata[3:0]};
          default: state_next.err = 1'b1;
        endcase
      end else if (avs_read) begin
        case (idx)
          serial_format_pkg::IDX_FORMAT: state_next.rdata = {24'h0, state_reg.format};
          serial_format_pkg::IDX_MODEM: state_next.rdata = {24'h0, modem_live};
          serial_format_pkg::IDX_DATA: begin
            state_next.rdata = {24'h0, state_reg.rx_buf};
            state_next.rx_full = 1'b0;
          end
          serial_format_pkg::IDX_AUX: state_next.rdata =
            {28'h0, state_reg.aux_drv, state_reg.aux_sync[3:2]};
          serial_format_pkg::IDX_IMASK: state_next.rdata = {24'h0, state_reg.imask};
          serial_format_pkg::IDX_LSTAT: state_next.rdata = {31'h0, state_reg.rx_full};
          default: state_next.err = 1'b1;
        endcase
      end
    end

    case (state_reg.tx_state)
      TX_IDLE: begin
        state_next.txd = 1'b1;
        if (state_reg.tx_hold_full && !state_reg.tx_paused) begin
          state_next.tx_shift = {1'b1, par_bit, state_reg.tx_hold, 1'b0} >> 0;
          if (!state_reg.format[FMT_PEN]) begin
            state_next.tx_shift = {2'b11, state_reg.tx_hold, 1'b0};
          end
          state_next.tx_shift[10:1] = state_next.tx_shift[10:1]
            | ({10{1'b1}} << (frame_bits));
          if (state_reg.format[FMT_PEN]) begin
            state_next.tx_shift[data_len + 4'd1] = par_bit;
          end
          state_next.tx_bits = frame_bits + 4'd1;
          state_next.tx_count = serial_format_pkg::BIT_CYCLES;
          // A data write in the same cycle refills the holding register, so it wins
          state_next.tx_hold_full = data_wr;
          state_next.tx_state = TX_SHIFT;
          state_next.txd = 1'b0;
        end
      end
      TX_SHIFT: begin
        if (state_reg.tx_count == 12'd1) begin
          state_next.tx_count = serial_format_pkg::BIT_CYCLES;
          state_next.tx_shift = {1'b1, state_reg.tx_shift[10:1]};
          state_next.txd = state_next.tx_shift[0];
          state_next.tx_bits = state_reg.tx_bits - 4'd1;
          if (state_reg.tx_bits == 4'd1) begin
            // stop length in half bits
            // Zero wraps through three down to one, giving four halves
            state_next.txd = 1'b1;
            state_next.tx_half_left = !state_reg.format[FMT_STOP] ? 2'd2
              : (state_reg.format[1:0] == 2'b00 ? 2'd3 : 2'd0);
            state_next.tx_count = serial_format_pkg::HALF_BIT_CYCLES;
            state_next.tx_state = TX_STOP;
          end
        end else begin
          state_next.tx_count = state_reg.tx_count - 12'd1;
        end
      end
      TX_STOP: begin
        state_next.txd = 1'b1;
        if (state_reg.tx_count == 12'd1) begin
          state_next.tx_count = serial_format_pkg::HALF_BIT_CYCLES;
          state_next.tx_half_left = state_reg.tx_half_left - 2'd1;
          if (state_reg.tx_half_left == 2'd1) begin
            state_next.tx_state = TX_IDLE;
          end
        end else begin
          state_next.tx_count = state_reg.tx_count - 12'd1;
        end
      end
      default: state_next.tx_state = TX_IDLE;
    endcase

    // Receiver, sampled mid-bit off the synchronised line
    case (state_reg.rx_state)
      RX_IDLE: begin
        if (!state_reg.rxd_sync[2]) begin
          state_next.rx_count = serial_format_pkg::BIT_CYCLES
            + serial_format_pkg::HALF_BIT_CYCLES;
          state_next.rx_bits = frame_bits;
          state_next.rx_shift = 9'h0;
          state_next.rx_state = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (state_reg.rx_count == 12'd1) begin
          state_next.rx_count = serial_format_pkg::BIT_CYCLES;
          state_next.rx_shift = {state_reg.rxd_sync[2], state_reg.rx_shift[8:1]};
          state_next.rx_bits = state_reg.rx_bits - 4'd1;
          if (state_reg.rx_bits == 4'd1) begin
            state_next.rx_state = RX_STOP;
          end
        end else begin
          state_next.rx_count = state_reg.rx_count - 12'd1;
        end
      end
      RX_STOP: begin
        if (state_reg.rx_count == 12'd1) begin
          // Right-justify the collected bits, drop parity
          state_next.rx_buf = 8'(state_reg.rx_shift >> (4'd9 - frame_bits));
          if (data_len != 4'd8) begin
            state_next.rx_buf = state_next.rx_buf & ~(8'hff << data_len);
          end
          state_next.rx_full = 1'b1;
          // software flow control acts on received characters
          if (state_reg.xon_enable && state_next.rx_buf == serial_format_pkg::XOFF_CHAR) begin
            state_next.tx_paused = 1'b1;
          end
          if (state_next.rx_buf == serial_format_pkg::XON_CHAR) begin
            state_next.tx_paused = 1'b0;
          end
          state_next.rx_state = RX_IDLE;
        end else begin
          state_next.rx_count = state_reg.rx_count - 12'd1;
        end
      end
      default: state_next.rx_state = RX_IDLE;
    endcase

    // Modem lines are registered from the next state, so they move with the frame
    // forced on, or active while a character is sent
    state_next.rts = state_next.modem[MC_RTS] | (state_next.tx_state != TX_IDLE);
    // forced on, or active around send and receive
    state_next.dtr = state_next.modem[MC_DTR] | (state_next.tx_state != TX_IDLE)
      | (state_next.rx_state != RX_IDLE);
    state_next.rate_sel = state_next.modem[MC_DRS];
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.format <= serial_format_pkg::FORMAT_RESET;
      state_reg.modem <= serial_format_pkg::MODEM_RESET;
      state_reg.imask <= serial_format_pkg::IMASK_RESET;
      state_reg.tx_state <= TX_IDLE;
      state_reg.rx_state <= RX_IDLE;
      state_reg.txd <= 1'b1;
      state_reg.rxd_sync <= 3'h7;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = ~state_reg.ack;
  assign avs_response_err = state_reg.err;
  assign txd = state_reg.txd;
  assign aux_driver_a = state_reg.aux_drv[1];
  assign aux_driver_b = state_reg.aux_drv[0];
  assign rts = state_reg.rts;
  assign dtr = state_reg.dtr;
  assign rate_select = state_reg.rate_sel;

  chk_rts_forced: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.modem[MC_RTS] |-> rts) else $error("rts not held active");
  chk_rts_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!state_reg.modem[MC_RTS] && state_reg.tx_state == TX_IDLE) |-> !rts)
    else $error("rts active while idle");
  chk_dtr_forced: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.modem[MC_DTR] |-> dtr) else $error("dtr not held active");
  chk_rate_sel: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(state_reg.modem[MC_DRS]) |-> ##[0:1] rate_select) else $error("rate select lag");
  chk_rx_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req && avs_read && !avs_write && idx == serial_format_pkg::IDX_DATA
     && state_reg.rx_state != RX_STOP) |=> !state_reg.rx_full) else $error("full not cleared");
  chk_rx_keep: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req && avs_read && idx == serial_format_pkg::IDX_DATA
     && state_reg.rx_state != RX_STOP) |=> $stable(state_reg.rx_buf)) else $error("buffer lost");
  chk_start_low: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg.tx_state == TX_IDLE && state_next.tx_state == TX_SHIFT) |=> !txd)
    else $error("no start bit");
  chk_stop_high: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.tx_state == TX_STOP |-> txd) else $error("stop not idle level");
  chk_tx_modem: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req && avs_write && idx == serial_format_pkg::IDX_DATA) |=> $stable(state_reg.modem))
    else $error("data write touched modem");
  chk_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
    bus_req |=> !avs_waitrequest) else $error("no answer in one cycle");
  chk_rts_busy: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.tx_state != TX_IDLE |-> rts) else $error("rts low during send");
  chk_dtr_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (!state_reg.modem[MC_DTR] && state_reg.tx_state == TX_IDLE
     && state_reg.rx_state == RX_IDLE) |-> !dtr) else $error("dtr active while idle");
  chk_dtr_busy: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg.tx_state != TX_IDLE || state_reg.rx_state != RX_IDLE) |-> dtr)
    else $error("dtr low during transfer");
  chk_rate_low: assert property (@(posedge clk) disable iff (!reset_n)
    !state_reg.modem[MC_DRS] |-> !rate_select) else $error("rate select not released");
  chk_idle_high: assert property (@(posedge clk) disable iff (!reset_n)
    state_reg.tx_state == TX_IDLE |-> txd) else $error("line not idle high");
  chk_full_set: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg.rx_state == RX_STOP && state_reg.rx_count == 12'd1) |=> state_reg.rx_full)
    else $error("full flag not set");
  chk_aux_upper: assert property (@(posedge clk) disable iff (!reset_n)
    (bus_req && avs_read && !avs_write && idx == serial_format_pkg::IDX_AUX)
    |=> avs_readdata[31:4] == 28'h0) else $error("aux upper bits set");
  chk_hold_keep: assert property (@(posedge clk) disable iff (!reset_n)
    data_wr |=> state_reg.tx_hold_full) else $error("written character lost");
  chk_answer_once: assert property (@(posedge clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
endmodule // serial_format_modem_ctrl

// [verif/serial_peer.sv]
module serial_peer (
  // Clock
  input wire logic clk,
  // Serial line
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = int'(serial_format_pkg::BIT_CYCLES);

  // Line rests at the stop level between characters
  initial begin
    rxd = 1'b1;
  end

  // Called right after a clock edge; eight data bits, no parity, one stop
  task automatic send(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (BITC) @(posedge clk);
    end
  endtask

  // Samples mid-bit, so a start found a few cycles late cannot flip a bit
  task automatic grab(input int n, output logic [15:0] bits, output logic ok);
    int k;
    bits = '0;
    k = 0;
    while (txd !== 1'b0 && k < 4 * BITC) begin
      @(posedge clk);
      k++;
    end
    ok = (k < 4 * BITC);
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      if (i < n - 1) begin
        repeat (BITC) @(posedge clk);
      end
    end
  endtask
endmodule // serial_peer

// [verif/tb_serial_format_modem_ctrl.sv]
module tb_serial_format_modem_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BITC = int'(serial_format_pkg::BIT_CYCLES);
  localparam logic [5:0] A_FMT = {serial_format_pkg::IDX_FORMAT, 2'b00};
  localparam logic [5:0] A_MC = {serial_format_pkg::IDX_MODEM, 2'b00};
  localparam logic [5:0] A_DAT = {serial_format_pkg::IDX_DATA, 2'b00};
  localparam logic [5:0] A_AUX = {serial_format_pkg::IDX_AUX, 2'b00};
  localparam logic [5:0] A_IMR = {serial_format_pkg::IDX_IMASK, 2'b00};
  localparam logic [5:0] A_IMW = {serial_format_pkg::IDX_IMASK_WR, 2'b00};
  localparam logic [5:0] A_LST = {serial_format_pkg::IDX_LSTAT, 2'b00};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, avs_response_err, txd, rxd, rts, dtr, rate_select;
  logic aux_driver_a, aux_driver_b;
  logic aux_receiver_a = 1'b0;
  logic aux_receiver_b = 1'b0;
  logic alt_layout = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;

  always #20 clk = ~clk;

  serial_format_modem_ctrl dut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response_err(avs_response_err), .txd(txd),
    .rxd(rxd), .rts(rts), .dtr(dtr), .rate_select(rate_select), .aux_driver_a(aux_driver_a),
    .aux_driver_b(aux_driver_b), .aux_receiver_a(aux_receiver_a),
    .aux_receiver_b(aux_receiver_b), .alt_layout(alt_layout));

  serial_peer peer (.clk(clk), .txd(txd), .rxd(rxd));

  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] q, output logic e);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      $display("[ERR] %0t bus answer timeout", $time);
      results();
    end
    q = avs_readdata[7:0];
    e = avs_response_err;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic e;
    bus(a, 1'b1, d, 4'h1, q, e);
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic e;
    bus(a, 1'b0, 8'h00, 4'h1, q, e);
    chk({7'h0, e}, 8'h00);
    chk(q, exp);
  endtask

  task automatic t_reset();
    rd(A_FMT, serial_format_pkg::FORMAT_RESET);
    rd(A_MC, serial_format_pkg::MODEM_RESET);
    rd(A_IMR, serial_format_pkg::IMASK_RESET);
    chk({5'h0, rate_select, rts, dtr}, 8'h00);
  endtask

  task automatic t_format();
    logic [7:0] q;
    logic e;
    wr(A_FMT, 8'h7f);
    rd(A_FMT, 8'h7f);
    wr(A_FMT, 8'h3b);
    rd(A_FMT, 8'h7b);
    wr(A_FMT, 8'hc2);
    rd(A_FMT, 8'hc2);
    bus(A_FMT, 1'b1, 8'h00, 4'h0, q, e);
    rd(A_FMT, 8'hc2);
  endtask

  task automatic t_modem();
    wr(A_MC, 8'hff);
    chk({5'h0, rate_select, rts, dtr}, 8'h07);
    rd(A_MC, 8'h07);
    wr(A_MC, 8'h04);
    chk({5'h0, rate_select, rts, dtr}, 8'h04);
    rd(A_MC, 8'h04);
  endtask

  task automatic t_aux();
    aux_receiver_a <= 1'b1;
    wr(A_AUX, 8'hff);
    chk({6'h0, aux_driver_a, aux_driver_b}, 8'h03);
    rd(A_AUX, 8'h0e);
    aux_receiver_a <= 1'b0;
    aux_receiver_b <= 1'b1;
    wr(A_AUX, 8'hf4);
    chk({6'h0, aux_driver_a, aux_driver_b}, 8'h01);
    rd(A_AUX, 8'h05);
  endtask

  task automatic t_imask();
    logic [7:0] q;
    logic e;
    wr(A_IMW, 8'ha5);
    rd(A_IMR, 8'h05);
    wr(A_IMW, 8'h5a);
    wr(A_IMR, 8'h00);
    rd(A_IMR, 8'h0a);
    bus(6'h00, 1'b0, 8'h00, 4'h1, q, e);
    chk({7'h0, e}, 8'h01);
    chk(q, 8'h00);
  endtask

  // Five bits, forced-one parity, 1.5 stops: the shortest frame that shows all three fields
  task automatic t_tx();
    logic [15:0] b;
    logic ok;
    wr(A_FMT, 8'hec);
    wr(A_MC, 8'h04);
    wr(A_DAT, 8'h16);
    peer.grab(8, b, ok);
    chk({7'h0, ok}, 8'h01);
    chk(b[7:0], 8'hec);
    chk({6'h0, rts, rate_select}, 8'h03);
    repeat (BITC * 8 / 10) @(posedge clk);
    chk({6'h0, rts, txd}, 8'h03);
    repeat (BITC * 4 / 10) @(posedge clk);
    chk({6'h0, rts, txd}, 8'h01);
    // Even parity over five bits must ignore holding bits above the character
    wr(A_FMT, 8'hdc);
    wr(A_DAT, 8'h36);
    peer.grab(7, b, ok);
    chk({7'h0, ok}, 8'h01);
    chk(b[7:0], 8'h6c);
  endtask

  task automatic t_rx();
    logic [7:0] q;
    logic e;
    wr(A_FMT, 8'hc3);
    fork
      peer.send(8'h5a);
      begin
        repeat (BITC * 5) @(posedge clk);
        chk({6'h0, dtr, rts}, 8'h02);
      end
    join
    repeat (BITC) @(posedge clk);
    bus(A_LST, 1'b0, 8'h00, 4'h1, q, e);
    chk(q & 8'h01, 8'h01);
    rd(A_DAT, 8'h5a);
    bus(A_LST, 1'b0, 8'h00, 4'h1, q, e);
    chk(q & 8'h01, 8'h00);
    rd(A_DAT, 8'h5a);
    chk({7'h0, dtr}, 8'h00);
  endtask

  task automatic t_alt();
    alt_layout <= 1'b1;
    reset_n <= 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    wr(A_FMT, 8'h43);
    rd(A_FMT, 8'h03);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_format();
    t_modem();
    t_aux();
    t_imask();
    t_tx();
    t_rx();
    t_alt();
    results();
  end
endmodule // tb_serial_format_modem_ctrl
